// ==== rtl/mode_map_regs.svh ====
`ifndef MODE_MAP_REGS_SVH
`define MODE_MAP_REGS_SVH

// ----------------------------------------
// APB register offsets
// ----------------------------------------
`define MAP_OFFSET 8'h00
`define EECFG_OFFSET 8'h04
`define STATUS_OFFSET 8'h08
`define BOOTCNT_OFFSET 8'h0c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MAP_RAM_PAGE_MSB 7
`define MAP_RAM_PAGE_LSB 4
`define MAP_REG_PAGE_MSB 3
`define MAP_REG_PAGE_LSB 0
`define EECFG_PAGE_MSB 7
`define EECFG_PAGE_LSB 4
`define EECFG_ON_BIT 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RAM_PAGE_RESET 4'h0
`define REG_PAGE_RESET 4'h1
`define EE_PAGE_RESET 4'hf
`define EE_ON_RESET 1'b1

// ----------------------------------------
// Memory map figures
// ----------------------------------------
`define REG_BLOCK_SIZE 12'h060
`define RAM_SIZE 12'h400
`define EE_PAGE_OFFSET 3'h7
`define TEST_HOLE_NIBBLE 4'hd
`define BOOT_PAGE 8'hbf
`define BOOT_VECTOR_BASE 8'hc0
`define BOOT_JUMP_TABLE 8'hc4
`define BOOT_LAST_ADDR 10'h3ff

// ----------------------------------------
// Timing
// ----------------------------------------
`define CHAR_BITS 10
`define IDLE_CHARS 4
`define BIT_CYCLES_DEFAULT 2170

`endif

// ==== rtl/mode_map_pkg.sv ====
package mode_map_pkg;

   typedef enum logic [3:0] {
      MODE_BOOT = 4'b0001,
      MODE_SINGLE = 4'b0010,
      MODE_TEST = 4'b0100,
      MODE_EXPANDED = 4'b1000
   } mode_type;

   typedef enum logic [2:0] {
      LOAD_IDLE = 3'b001,
      LOAD_RUN = 3'b010,
      LOAD_DONE = 3'b100
   } load_state_type;

endpackage

// ==== rtl/boot_rom.sv ====
`timescale 1ns/1ps
`include "mode_map_regs.svh"

module boot_rom #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 256
)
(
   input wire logic sys_clk,
   input wire logic [$clog2(DEPTH)-1:0] addr,
   output logic [WIDTH-1:0] rdata
);

   // ----------------------------------------
   // Vector contents
   // ----------------------------------------
   function automatic logic [WIDTH-1:0] romByte(input logic [7:0] a);
      logic [7:0] slot;
      logic [7:0] v;
      slot = (a - `BOOT_VECTOR_BASE) >> 1;
      v = 8'h00;
      if (a == 8'hfe)
         v = `BOOT_PAGE;
      else if (a == 8'hff)
         v = 8'h00;
      else if (a >= `BOOT_VECTOR_BASE && !a[0])
         v = 8'h00;
      else if (a >= `BOOT_VECTOR_BASE)
         v = 8'(`BOOT_JUMP_TABLE + slot * 8'h03);
      return WIDTH'(v);
   endfunction

   always_ff @(posedge sys_clk)
   begin
      rdata <= romByte(8'(addr));
   end

endmodule

// ==== rtl/mode_select_memory_map_decoder.sv ====
`timescale 1ns/1ps
`include "mode_map_regs.svh"

// Function
// R01 - Mode comes from the two mode pins sampled while reset is held.
// R02 - Single-chip mode drives no external bus; ports B, C, F stay GPIO.
// R03 - Expanded mode reaches a 64-Kbyte space: on-chip plus external.
// R04 - Expanded: port B high address, port F low address, port C data, rw direction.
// R05 - Special test acts like expanded; vectors are fetched externally.
// R06 - Bootstrap mode enables a 256-byte boot ROM at the top page BF.
// R07 - Bootstrap vectors come from boot ROM BFC0-BFFF, then bootloader runs.
// R08 - Normal modes keep the boot ROM off the map.
// R09 - Loader takes up to 1024 bytes into RAM, ends on idle or last byte.
// R10 - Loader sets port D to wired-OR operation.
// R11 - Boot ROM vectors point into a RAM jump table.
// R12 - 96-byte register block at 1000, movable to any 4-Kbyte page.
// R13 - 1024-byte RAM at 0000, movable to any 4-Kbyte page.
// R14 - Registers win over RAM when both share a page.
// R15 - EEPROM at FE00 after reset when enabled by configuration.
// R16 - Expanded and test modes place EEPROM at xE00 of selected page.
// R17 - Single-chip and bootstrap force EEPROM on at default place.
// R18 - Special test mode starts with EEPROM disabled.
// R19 - Test mode keeps zD00-zDFF off the external bus.
// R20 - On-chip resources decode identically in expanded and single-chip modes; code moves and disables EEPROM only in expanded and test modes.
// R21 - Unclaimed accesses in expanded and test modes go external.
// R22 - Each mode pin code maps to one mode, latched once per reset.
module mode_select_memory_map_decoder
   import mode_map_pkg::*;
#(
   parameter int BIT_CYCLES = `BIT_CYCLES_DEFAULT
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic modeSelectA,
   input wire logic modeSelectB,
   input wire logic [15:0] cpuAddr,
   input wire logic cpuValid,
   input wire logic cpuWrite,
   input wire logic [7:0] cpuWdata,
   output logic ramSel,
   output logic regSel,
   output logic eepromSel,
   output logic bootRomSel,
   output logic extSel,
   output logic [9:0] ramOffset,
   output logic [6:0] regOffset,
   output logic [8:0] eepromOffset,
   output logic [7:0] bootRomData,
   output logic [7:0] portBOut,
   output logic portBOe,
   output logic [7:0] portFOut,
   output logic portFOe,
   output logic [7:0] portCOut,
   output logic portCOe,
   input wire logic [7:0] portCIn,
   output logic [7:0] extRdata,
   output logic rwOut,
   input wire logic [7:0] gpioBOut,
   input wire logic gpioBOe,
   input wire logic [7:0] gpioCOut,
   input wire logic gpioCOe,
   input wire logic [7:0] gpioFOut,
   input wire logic gpioFOe,
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   output logic serialEnable,
   output logic portDWiredOr,
   output logic ramWrEn,
   output logic [9:0] ramWrAddr,
   output logic [7:0] ramWrData,
   output logic bootDone,
   output logic jumpToZero
);

   localparam int IDLE_CYCLES = `IDLE_CHARS * `CHAR_BITS * BIT_CYCLES;

   // ----------------------------------------
   // Mode pin and port C input synchronisers
   // ----------------------------------------
   logic [1:0] modeMeta_reg;
   logic [1:0] modeSync_reg;
   logic [7:0] portCMeta_reg;
   logic [7:0] portCSync_reg;

   always_ff @(posedge sys_clk)
   begin
      modeMeta_reg <= {modeSelectB, modeSelectA};
      modeSync_reg <= modeMeta_reg;
      portCMeta_reg <= portCIn;
      portCSync_reg <= portCMeta_reg;
   end

   // ----------------------------------------
   // Mode latch
   // ----------------------------------------
   mode_type mode_reg;
   mode_type mode_next;

   always_comb
   begin
      case (modeSync_reg) // R22
         2'b00: mode_next = MODE_BOOT;
         2'b01: mode_next = MODE_SINGLE;
         2'b10: mode_next = MODE_TEST;
         2'b11: mode_next = MODE_EXPANDED;
         default: mode_next = MODE_SINGLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         mode_reg <= mode_next; // R01
   end

   logic isBoot;
   logic isSingle;
   logic isTest;
   logic isExpanded;
   logic busMode;

   assign isBoot = (mode_reg == MODE_BOOT);
   assign isSingle = (mode_reg == MODE_SINGLE);
   assign isTest = (mode_reg == MODE_TEST);
   assign isExpanded = (mode_reg == MODE_EXPANDED);
   assign busMode = isExpanded | isTest; // R05

   // ----------------------------------------
   // Map registers
   // ----------------------------------------
   logic [3:0] ramPage_reg;
   logic [3:0] regPage_reg;
   logic [3:0] eePage_reg;
   logic eeOn_reg;
   logic apbWrite;
   logic apbSetup;

   assign apbWrite = psel & penable & pwrite;
   assign apbSetup = psel & ~penable;
   assign pready = 1'b1;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ramPage_reg <= `RAM_PAGE_RESET; // R13
         regPage_reg <= `REG_PAGE_RESET; // R12
      end
      else if (apbWrite && paddr == `MAP_OFFSET)
      begin
         ramPage_reg <= pwdata[`MAP_RAM_PAGE_MSB:`MAP_RAM_PAGE_LSB];
         regPage_reg <= pwdata[`MAP_REG_PAGE_MSB:`MAP_REG_PAGE_LSB];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         eePage_reg <= `EE_PAGE_RESET; // R15
         eeOn_reg <= `EE_ON_RESET & (mode_next != MODE_TEST); // R18
      end
      else if (apbWrite && paddr == `EECFG_OFFSET)
      begin
         eePage_reg <= pwdata[`EECFG_PAGE_MSB:`EECFG_PAGE_LSB];
         eeOn_reg <= pwdata[`EECFG_ON_BIT];
      end
   end

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   logic [3:0] eePageEff;
   logic eeOnEff;
   logic hitReg;
   logic hitRam;
   logic hitBoot;
   logic hitEe;
   logic hitHole;
   logic hitExt;

   assign eePageEff = (isSingle | isBoot) ? `EE_PAGE_RESET : eePage_reg; // R16 R17
   assign eeOnEff = (isSingle | isBoot) | eeOn_reg; // R17
   assign hitReg = (cpuAddr[15:12] == regPage_reg) && (cpuAddr[11:0] < `REG_BLOCK_SIZE); // R12
   assign hitRam = (cpuAddr[15:12] == ramPage_reg) && (cpuAddr[11:0] < `RAM_SIZE); // R13
   assign hitBoot = isBoot && (cpuAddr[15:8] == `BOOT_PAGE); // R06 R08
   assign hitEe = eeOnEff && (cpuAddr[15:12] == eePageEff)
      && (cpuAddr[11:9] == `EE_PAGE_OFFSET); // R15 R16
   assign hitHole = isTest && (cpuAddr[15:12] == eePage_reg)
      && (cpuAddr[11:8] == `TEST_HOLE_NIBBLE); // R19
   assign hitExt = busMode && !(hitReg | hitRam | hitBoot | hitEe | hitHole); // R21 R03

   // Registered selects, fixed priority
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         regSel <= 1'b0;
         ramSel <= 1'b0;
         bootRomSel <= 1'b0;
         eepromSel <= 1'b0;
         extSel <= 1'b0;
         regOffset <= 7'h00;
         ramOffset <= 10'h000;
         eepromOffset <= 9'h000;
      end
      else
      begin
         regSel <= cpuValid & hitReg; // R14 R20
         ramSel <= cpuValid & hitRam & ~hitReg; // R14
         bootRomSel <= cpuValid & hitBoot & ~hitReg & ~hitRam; // R07
         eepromSel <= cpuValid & hitEe & ~hitReg & ~hitRam & ~hitBoot;
         extSel <= cpuValid & hitExt; // R21
         regOffset <= cpuAddr[6:0];
         ramOffset <= cpuAddr[9:0];
         eepromOffset <= cpuAddr[8:0];
      end
   end

   // ----------------------------------------
   // Boot ROM
   // ----------------------------------------
   boot_rom #(
      .WIDTH(8),
      .DEPTH(256)
   ) bootRom (
      .sys_clk(sys_clk),
      .addr(cpuAddr[7:0]),
      .rdata(bootRomData) // R07 R11
   );

   // ----------------------------------------
   // Expansion bus pins
   // ----------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         portBOut <= 8'h00;
         portFOut <= 8'h00;
         portCOut <= 8'h00;
         portBOe <= 1'b0;
         portFOe <= 1'b0;
         portCOe <= 1'b0;
         rwOut <= 1'b1;
      end
      else if (busMode)
      begin
         portBOe <= 1'b1;
         portFOe <= 1'b1;
         if (cpuValid && hitExt)
         begin
            portBOut <= cpuAddr[15:8]; // R04
            portFOut <= cpuAddr[7:0]; // R04
            portCOut <= cpuWdata; // R04
            portCOe <= cpuWrite;
            rwOut <= ~cpuWrite; // R04
         end
         else
         begin
            portCOe <= 1'b0;
            rwOut <= 1'b1;
         end
      end
      else
      begin
         portBOut <= gpioBOut; // R02
         portFOut <= gpioFOut; // R02
         portCOut <= gpioCOut; // R02
         portBOe <= gpioBOe;
         portFOe <= gpioFOe;
         portCOe <= gpioCOe;
         rwOut <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         extRdata <= 8'h00;
      else
         extRdata <= portCSync_reg;
   end

   // ----------------------------------------
   // Bootloader engine
   // ----------------------------------------
   load_state_type loadState_reg;
   logic [10:0] loadCount_reg;
   logic [31:0] idleCount_reg;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         loadState_reg <= LOAD_IDLE;
         loadCount_reg <= 11'h000;
         idleCount_reg <= 32'h0;
         ramWrEn <= 1'b0;
         ramWrAddr <= 10'h000;
         ramWrData <= 8'h00;
         jumpToZero <= 1'b0;
      end
      else
      begin
         ramWrEn <= 1'b0;
         jumpToZero <= 1'b0;
         case (loadState_reg)
            LOAD_IDLE:
            begin
               if (isBoot && rxValid)
               begin
                  ramWrEn <= 1'b1; // R09
                  ramWrAddr <= 10'h000;
                  ramWrData <= rxData;
                  loadCount_reg <= 11'h001;
                  idleCount_reg <= 32'h0;
                  loadState_reg <= LOAD_RUN;
               end
            end
            LOAD_RUN:
            begin
               if (rxValid)
               begin
                  ramWrEn <= 1'b1;
                  ramWrAddr <= loadCount_reg[9:0];
                  ramWrData <= rxData;
                  loadCount_reg <= loadCount_reg + 11'h001;
                  idleCount_reg <= 32'h0;
                  if (loadCount_reg[9:0] == `BOOT_LAST_ADDR)
                  begin
                     jumpToZero <= 1'b1; // R09
                     loadState_reg <= LOAD_DONE;
                  end
               end
               else if (idleCount_reg == 32'(IDLE_CYCLES - 1))
               begin
                  jumpToZero <= 1'b1; // R09
                  loadState_reg <= LOAD_DONE;
               end
               else
                  idleCount_reg <= idleCount_reg + 32'h1;
            end
            LOAD_DONE:
            begin
               loadState_reg <= LOAD_DONE;
            end
            default:
               loadState_reg <= LOAD_IDLE;
         endcase
      end
   end

   assign bootDone = (loadState_reg == LOAD_DONE);
   assign serialEnable = isBoot & ~bootDone; // R09
   assign portDWiredOr = isBoot; // R10

   // ----------------------------------------
   // APB read path
   // ----------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end
      else if (apbSetup)
      begin
         pslverr <= 1'b0;
         case (paddr)
            `MAP_OFFSET:
               prdata <= {24'h0, ramPage_reg, regPage_reg};
            `EECFG_OFFSET:
               prdata <= {24'h0, eePage_reg, 3'h0, eeOn_reg};
            `STATUS_OFFSET:
               prdata <= {26'h0, bootDone, eeOnEff, mode_reg};
            `BOOTCNT_OFFSET:
               prdata <= {21'h0, loadCount_reg};
            default:
            begin
               prdata <= 32'h0;
               pslverr <= 1'b1;
            end
         endcase
      end
   end

endmodule

// ==== verif/mode_map_decoder_props.sv ====
`timescale 1ns/1ps
module mode_map_decoder_props
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [15:0] cpuAddr,
   input wire logic cpuValid,
   input wire logic cpuWrite,
   input wire logic ramSel,
   input wire logic regSel,
   input wire logic eepromSel,
   input wire logic bootRomSel,
   input wire logic extSel,
   input wire logic [9:0] ramOffset,
   input wire logic [6:0] regOffset,
   input wire logic [8:0] eepromOffset,
   input wire logic [7:0] portBOut,
   input wire logic portBOe,
   input wire logic [7:0] portFOut,
   input wire logic portFOe,
   input wire logic rwOut,
   input wire logic serialEnable,
   input wire logic portDWiredOr,
   input wire logic bootDone,
   input wire logic jumpToZero
);
   // ----------------------------------------
   // Decode, bus and loader checks
   // ----------------------------------------
   logic [4:0] sels;
   logic [15:0] prevAddr;
   logic prevWrite;
   assign sels = {ramSel, regSel, eepromSel, bootRomSel, extSel};
   always_ff @(posedge sys_clk)
   begin
      prevAddr <= cpuAddr;
      prevWrite <= cpuWrite;
   end
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   property p_onehot;
      $onehot0(sels);
   endproperty
   a_onehot: assert property (p_onehot) else $error("two selects high");
   property p_idle;
      !cpuValid |=> sels == 5'h00;
   endproperty
   a_idle: assert property (p_idle) else $error("select without access");
   property p_reg;
      regSel |-> prevAddr[11:0] < 12'h060 && regOffset == prevAddr[6:0];
   endproperty
   a_reg: assert property (p_reg) else $error("bad register select");
   property p_ram;
      ramSel |-> prevAddr[11:10] == 2'b00 && ramOffset == prevAddr[9:0];
   endproperty
   a_ram: assert property (p_ram) else $error("bad ram select");
   property p_ee;
      eepromSel |-> prevAddr[11:9] == 3'h7 && eepromOffset == prevAddr[8:0];
   endproperty
   a_ee: assert property (p_ee) else $error("bad eeprom select");
   property p_rom;
      bootRomSel |-> prevAddr[15:8] == 8'hbf && portDWiredOr;
   endproperty
   a_rom: assert property (p_rom) else $error("bad boot rom select");
   property p_ext;
      extSel |-> portBOe && portFOe && {portBOut, portFOut} == prevAddr && rwOut == !prevWrite;
   endproperty
   a_ext: assert property (p_ext) else $error("bad external cycle");
   property p_jump;
      jumpToZero |=> bootDone && !jumpToZero && !serialEnable;
   endproperty
   a_jump: assert property (p_jump) else $error("bad loader end");
   c_ext: cover property (extSel && !rwOut);
   c_rom: cover property (bootRomSel);
   c_jump: cover property (jumpToZero);
endmodule

bind mode_select_memory_map_decoder mode_map_decoder_props u_props
(
   .sys_clk, .sys_rst, .cpuAddr, .cpuValid, .cpuWrite, .ramSel, .regSel, .eepromSel,
   .bootRomSel, .extSel, .ramOffset, .regOffset, .eepromOffset, .portBOut, .portBOe,
   .portFOut, .portFOe, .rwOut, .serialEnable, .portDWiredOr, .bootDone, .jumpToZero
);

// ==== verif/ext_bus_model.sv ====
`timescale 1ns/1ps
module ext_bus_model
(
   input wire logic sys_clk,
   input wire logic [7:0] portBOut,
   input wire logic portBOe,
   input wire logic [7:0] portFOut,
   input wire logic portFOe,
   input wire logic [7:0] portCOut,
   input wire logic portCOe,
   input wire logic rwOut,
   output logic [7:0] portCIn
);
   // ----------------------------------------
   // External memory on the expansion bus
   // ----------------------------------------
   logic [7:0] mem [256];
   logic [7:0] lastC = 8'h00;
   always @(posedge sys_clk)
   begin
      if (portBOe && portFOe && portCOe && !rwOut)
         mem[portFOut] <= portCOut;
      lastC <= portCIn;
   end
   // Released data lines flip every cycle
   assign portCIn = (portBOe && portFOe && rwOut && !portCOe) ? mem[portFOut] : ~lastC;
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
   import mode_map_pkg::*;
;
   localparam int BITC = 4;
   localparam int IDLE = 4 * 10 * BITC;
   localparam logic [4:0] S_RAM = 5'h10, S_REG = 5'h08, S_EE = 5'h04, S_ROM = 5'h02;
   localparam logic [4:0] S_EXT = 5'h01;
   localparam mode_type MODES [4] = '{MODE_BOOT, MODE_SINGLE, MODE_TEST, MODE_EXPANDED};
   localparam logic [15:0] VA [4] = '{16'hbffe, 16'hbfff, 16'hbfc0, 16'hbfc1};
   localparam logic [7:0] VD [4] = '{8'hbf, 8'h00, 8'h00, 8'hc4};
   logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr, cpuWdata, portBOut, portFOut, portCOut, portCIn, extRdata, bootRomData;
   logic [7:0] rxData, gpioBOut, gpioCOut, gpioFOut, ramWrData;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] cpuAddr;
   logic [9:0] ramOffset, ramWrAddr;
   logic [6:0] regOffset;
   logic [8:0] eepromOffset;
   logic [4:0] sel;
   logic modeSelectA, modeSelectB, cpuValid, cpuWrite, ramSel, regSel, eepromSel, bootRomSel;
   logic extSel, portBOe, portFOe, portCOe, rwOut, gpioBOe, gpioCOe, gpioFOe, rxValid;
   logic serialEnable, portDWiredOr, ramWrEn, bootDone, jumpToZero;
   int errorCnt, checked, cnt;

   mode_select_memory_map_decoder #(.BIT_CYCLES(BITC)) u_dut
   (
      .sys_clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata,
      .pslverr, .modeSelectA, .modeSelectB, .cpuAddr, .cpuValid, .cpuWrite, .cpuWdata,
      .ramSel, .regSel, .eepromSel, .bootRomSel, .extSel, .ramOffset, .regOffset,
      .eepromOffset, .bootRomData, .portBOut, .portBOe, .portFOut, .portFOe, .portCOut,
      .portCOe, .portCIn, .extRdata, .rwOut, .gpioBOut, .gpioBOe, .gpioCOut, .gpioCOe,
      .gpioFOut, .gpioFOe, .rxValid, .rxData, .serialEnable, .portDWiredOr, .ramWrEn,
      .ramWrAddr, .ramWrData, .bootDone, .jumpToZero
   );
   ext_bus_model u_ext
   (
      .sys_clk, .portBOut, .portBOe, .portFOut, .portFOe, .portCOut, .portCOe, .rwOut,
      .portCIn
   );

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", checked, errorCnt);
      if (errorCnt == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic rst(input logic [1:0] code);
      {modeSelectB, modeSelectA} <= code;
      sys_rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      #1;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1)
         @(posedge sys_clk);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic cpu(input logic [15:0] a, input logic w, input logic [7:0] d, input int n);
      @(posedge sys_clk);
      {cpuAddr, cpuWrite, cpuWdata, cpuValid} <= {a, w, d, 1'b1};
      repeat (n) @(posedge sys_clk);
      cpuValid <= 1'b0;
      #1;
      sel = {ramSel, regSel, eepromSel, bootRomSel, extSel};
   endtask
   task automatic dec(input logic [15:0] a, input logic [4:0] e);
      cpu(a, 1'b0, 8'h00, 1);
      check("select", {27'h0, sel}, {27'h0, e});
   endtask
   task automatic rx(input logic [7:0] d, input logic [9:0] a);
      @(posedge sys_clk);
      {rxData, rxValid} <= {d, 1'b1};
      @(posedge sys_clk);
      rxValid <= 1'b0;
      #1;
      check("ram_write", {13'h0, ramWrEn, ramWrData, ramWrAddr}, {13'h0, 1'b1, d, a});
   endtask
   task automatic waitJump(input int lim);
      cnt = 0;
      while (jumpToZero !== 1'b1 && cnt < lim)
      begin
         @(posedge sys_clk);
         #1;
         cnt++;
      end
   endtask

   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial
   begin
      repeat (10000) @(posedge sys_clk);
      errorCnt++;
      summarize();
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, cpuAddr, cpuValid, cpuWrite, cpuWdata} = '0;
      {rxValid, rxData, gpioBOut, gpioBOe, gpioCOut, gpioCOe, gpioFOut, gpioFOe} = '0;
      {sys_rst, modeSelectA, modeSelectB, errorCnt, checked} = '0;
      for (int m = 0; m < 4; m++)
      begin
         rst(2'(m));
         apb(1'b0, 8'h08, 32'h0);
         check("mode", {28'h0, rd[3:0]}, {28'h0, MODES[m]});
         check("eeprom_on", {31'h0, rd[4]}, {31'h0, m != 2});
      end
      dec(16'h1005, S_REG);
      dec(16'h105f, S_REG);
      dec(16'h1060, S_EXT);
      dec(16'h03ff, S_RAM);
      dec(16'h0400, S_EXT);
      dec(16'hfe00, S_EE);
      dec(16'hbfc0, S_EXT);
      cpu(16'h8033, 1'b1, 8'h5a, 1);
      check("bus_write", {portBOut, portFOut, portCOut, 6'h0, portCOe, rwOut}, 32'h80335a02);
      cpu(16'h8033, 1'b0, 8'h00, 5);
      check("bus_read", {23'h0, rwOut, extRdata}, {23'h0, 1'b1, 8'h5a});
      apb(1'b1, 8'h00, 32'h22);
      dec(16'h2010, S_REG);
      dec(16'h2060, S_RAM);
      dec(16'h1005, S_EXT);
      dec(16'h0000, S_EXT);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped", {31'h0, err}, 32'h1);
      apb(1'b1, 8'h04, 32'h31);
      dec(16'h3e00, S_EE);
      dec(16'hfe00, S_EXT);
      apb(1'b1, 8'h04, 32'h30);
      dec(16'h3e00, S_EXT);
      rst(2'b10);
      dec(16'hfe00, S_EXT);
      dec(16'hfd40, 5'h00);
      dec(16'hfffe, S_EXT);
      apb(1'b1, 8'h04, 32'h51);
      dec(16'h5e00, S_EE);
      dec(16'h5d00, 5'h00);
      dec(16'h5c00, S_EXT);
      rst(2'b01);
      {gpioBOut, gpioBOe, gpioFOut, gpioFOe} <= {8'ha5, 1'b1, 8'h96, 1'b1};
      {gpioCOut, gpioCOe} <= {8'h3c, 1'b1};
      dec(16'h8000, 5'h00);
      check("gpio", {14'h0, portBOe, portBOut, portFOe, portFOut}, 32'h34b96);
      check("gpio_c", {23'h0, portCOe, portCOut}, 32'h13c);
      apb(1'b1, 8'h04, 32'h30);
      dec(16'hfe00, S_EE);
      dec(16'hbf00, 5'h00);
      rst(2'b00);
      check("boot_pins", {30'h0, portDWiredOr, serialEnable}, 32'h3);
      dec(16'hbf10, S_ROM);
      dec(16'h8000, 5'h00);
      dec(16'hfe00, S_EE);
      for (int i = 0; i < 4; i++)
      begin
         dec(VA[i], S_ROM);
         check("vector", {24'h0, bootRomData}, {24'h0, VD[i]});
      end
      for (int i = 0; i < 3; i++)
         rx(8'h40 + 8'(i), 10'(i));
      waitJump(2 * IDLE);
      check("idle_jump", {30'h0, jumpToZero, cnt > IDLE - 8}, 32'h3);
      apb(1'b0, 8'h0c, 32'h0);
      check("loaded", rd, 32'h3);
      check("done", {30'h0, bootDone, serialEnable}, 32'h2);
      rst(2'b00);
      for (int i = 0; i < 1024; i++)
         rx(8'(i), 10'(i));
      waitJump(8);
      check("last_jump", {31'h0, jumpToZero}, 32'h1);
      summarize();
   end
endmodule
